//--- rtl/wkm_matcher.sv
/*
  Wake-on-specific-key matcher: receives keyboard frames, compares the data
  byte with a programmed code, checks start, parity and stop, and raises a
  wake event. Clock gating is stood in for by holding the line filter in
  reset and the receiver idle while the feature is off.
  Assumes a simple byte register port from the runtime block with one-cycle
  read and write strobes on this clock, and a keyboard driving its own clock
  and data lines into this domain, resting high between frames.
*/
`timescale 1ns/1ps
//
// Contract
// - Key code register cleared only on standby reset
// - Match status bit 5, enable bit 5
// - High level is one, low is zero
// - Frame starts at fall after long high
// - Sample every fall; data bit 0 second
// - Compare data with code after ninth fall
// - Accept frame only with odd parity
// - Set match status within 100us of tenth
// - Return idle after 11 clocks, repeat while on
// - Long high mid-frame abandons frame silently
// - Config bit 1 disables matcher, default on
// - Disabled matcher logic stops its clocking; here the filter is held in reset and the receiver held idle
// - Wake event only with enable bit 5
// - Status sets regardless; wake needs both enables
module wkm_matcher
  import wkm_pkg::*;
#(
  parameter int IDLE_MIN_CYC = WKM_IDLE_MIN_CYC,
  parameter int IDLE_MAX_CYC = WKM_IDLE_MAX_CYC,
  parameter int FILT_CYC     = WKM_GLITCH_CYC
) (
  // Clock and standby-supply reset
  core_clk,
  resetn,
  // Keyboard lines
  kbd_clk_in,
  kbd_dat_in,
  // Runtime register port
  reg_wr,
  reg_rd,
  reg_addr,
  reg_wdata,
  reg_rdata,
  // Wake status and enables
  match_sts_clr,
  match_sts,
  match_en,
  global_wake_enable,
  wake_out
);
  input  wire logic       core_clk;
  input  wire logic       resetn;
  input  wire logic       kbd_clk_in;
  input  wire logic       kbd_dat_in;
  input  wire logic       reg_wr;
  input  wire logic       reg_rd;
  input  wire logic [7:0] reg_addr;
  input  wire logic [7:0] reg_wdata;
  output logic      [7:0] reg_rdata;
  input  wire logic       match_sts_clr;
  output logic            match_sts;
  input  wire logic       match_en;
  input  wire logic       global_wake_enable;
  output logic            wake_out;

  // Reset release through two flops
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Enable inputs come from sibling logic on this clock; resync anyway for safety
  logic [1:0] en_meta_q, en_q;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en_meta_q <= 2'h0;
      en_q      <= 2'h0;
    end else begin
      en_meta_q <= {match_en, global_wake_enable};
      en_q      <= en_meta_q;
    end
  end

  // Offset decode, shared by the write path and the read mux
  function automatic logic hits_ofs(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Register file
  wkm_wreq_type wreq;
  logic [7:0]   key_code_q, key_code_d;
  logic [7:0]   clk_cfg_q, clk_cfg_d;
  logic [7:0]   rdata_q, rdata_d;
  logic         feat_off;

  assign wreq     = '{wr: reg_wr, addr: reg_addr, data: reg_wdata};
  assign feat_off = clk_cfg_q[WKM_DISABLE_BIT];

  // Write decode; other offsets are ignored
  always_comb begin
    key_code_d = key_code_q;
    clk_cfg_d  = clk_cfg_q;
    if (wreq.wr && hits_ofs(wreq.addr, WKM_KEY_CODE_OFS)) begin
      key_code_d = wreq.data;
    end else if (wreq.wr && hits_ofs(wreq.addr, WKM_CLK_CFG_OFS)) begin
      clk_cfg_d = wreq.data;
    end
  end

  // Only the standby-supply reset clears the code
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      key_code_q <= WKM_KEY_CODE_RST;
      clk_cfg_q  <= WKM_CLK_CFG_RST;
    end else begin
      key_code_q <= key_code_d;
      clk_cfg_q  <= clk_cfg_d;
    end
  end

  // Read mux; registered so the port has no path from the address pins
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (hits_ofs(reg_addr, WKM_KEY_CODE_OFS)) begin
        rdata_d = key_code_q;
      end else if (hits_ofs(reg_addr, WKM_CLK_CFG_OFS)) begin
        rdata_d = clk_cfg_q;
      end else begin
        rdata_d = 8'h00; // Unmapped offsets read as zero
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // Line filter held in reset while disabled, freezing its toggling
  logic         filt_rst_n;
  wkm_link_type lines;
  // Both terms come from flops, so the derived reset cannot glitch
  assign filt_rst_n = rst_n_q & ~feat_off;

  wkm_line_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .core_clk (core_clk),
    .rst_n    (filt_rst_n),
    .kclk_pin (kbd_clk_in),
    .kdat_pin (kbd_dat_in),
    .lines    (lines)
  );

  // Receiver state
  // Edge counter runs from 1 at the start bit to 11 at the stop bit
  wkm_state_type state_q, state_d;
  logic          kclk_prev_q;
  logic [15:0]   high_cnt_q, high_cnt_d;
  logic [3:0]    edge_cnt_q, edge_cnt_d;
  logic [7:0]    shift_q, shift_d;
  logic          code_eq_q, code_eq_d;
  logic          par_ok_q, par_ok_d;
  logic          start_ok_q, start_ok_d;
  logic          sts_q, sts_d;
  logic          wake_q, wake_d;
  logic          fall, hit;

  // Falling edge of the filtered clock; the previous flop resets to idle high
  assign fall = kclk_prev_q & ~lines.kclk;

  // Frame receive, match and abort logic
  always_comb begin
    state_d    = state_q;
    high_cnt_d = high_cnt_q;
    edge_cnt_d = edge_cnt_q;
    shift_d    = shift_q;
    code_eq_d  = code_eq_q;
    par_ok_d   = par_ok_q;
    start_ok_d = start_ok_q;
    hit        = 1'b0;
    // Measure how long the clock line has stayed high
    // Saturates rather than wrapping, so a long idle never looks short
    if (!lines.kclk) begin
      high_cnt_d = 16'h0000;
    end else if (high_cnt_q != 16'hFFFF) begin
      high_cnt_d = high_cnt_q + 16'h0001;
    end
    case (state_q)
      WKM_IDLE: begin
        // Needs a full idle-high gap before a frame may begin
        edge_cnt_d = 4'h0;
        if (high_cnt_q >= 16'(IDLE_MIN_CYC)) begin
          state_d = WKM_ARMED;
        end
      end
      WKM_ARMED: begin
        if (fall) begin
          state_d    = WKM_RECV; // Start bit captured on this edge
          edge_cnt_d = WKM_EDGE_START;
          start_ok_d = ~lines.kdat; // A high start bit spoils the frame
        end
      end
      WKM_RECV: begin
        if (fall) begin
          edge_cnt_d = edge_cnt_q + 4'h1;
          if (edge_cnt_q < 4'h9) begin
            // Line level taken directly as bit value, LSB first
            shift_d = {lines.kdat, shift_q[7:1]};
          end
          if (edge_cnt_q == 4'h9) begin
            // Byte complete after ninth edge; latch compare
            code_eq_d = (shift_q == key_code_q);
          end
          if (edge_cnt_q + 4'h1 == WKM_EDGE_PARITY) begin
            par_ok_d = ^{shift_q, lines.kdat}; // Odd count of ones
          end
          if (edge_cnt_q + 4'h1 == WKM_EDGE_STOP) begin
            // Stop bit on clock 11; flag set right away, well inside 100us
            hit     = start_ok_q & code_eq_q & par_ok_q & lines.kdat;
            state_d = WKM_IDLE; // Restart detection
          end
        end else if (lines.kclk && high_cnt_q > 16'(IDLE_MAX_CYC)) begin
          // Upper idle bound, so a slow but legal keyboard is not cut off
          state_d = WKM_IDLE; // Stalled frame dropped, no event
        end
      end
      default: state_d = WKM_IDLE;
    endcase
  end

  // Hardware set beats software clear; status ignores global enable
  // A clear that meets a new match loses, so no wake is ever dropped
  always_comb begin
    sts_d = sts_q;
    if (match_sts_clr) begin
      sts_d = 1'b0;
    end
    if (hit) begin
      sts_d = 1'b1;
    end
    // Wake only with both enables
    wake_d = sts_q & en_q[1] & en_q[0] & ~feat_off;
  end

  // Receiver registers; held idle while the feature is off
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q     <= WKM_IDLE;
      kclk_prev_q <= 1'b1;
      high_cnt_q  <= 16'h0000;
      edge_cnt_q  <= 4'h0;
      shift_q     <= 8'h00;
      start_ok_q  <= 1'b0;
      code_eq_q   <= 1'b0;
      par_ok_q    <= 1'b0;
    end else if (feat_off) begin
      state_q     <= WKM_IDLE;
      kclk_prev_q <= 1'b1;
      high_cnt_q  <= 16'h0000;
      edge_cnt_q  <= 4'h0;
      shift_q     <= shift_q;
      start_ok_q  <= 1'b0;
      code_eq_q   <= 1'b0;
      par_ok_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      kclk_prev_q <= lines.kclk;
      high_cnt_q  <= high_cnt_d;
      edge_cnt_q  <= edge_cnt_d;
      shift_q     <= shift_d;
      start_ok_q  <= start_ok_d;
      code_eq_q   <= code_eq_d;
      par_ok_q    <= par_ok_d;
    end
  end

  // Status and wake output registers
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sts_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      sts_q  <= sts_d;
      wake_q <= wake_d;
    end
  end

  assign match_sts = sts_q;
  assign wake_out  = wake_q;

endmodule

//--- rtl/wkm_pkg.sv
/*
  Package for the wake-on-key matcher: register offsets, field positions,
  reset values, timing constants, state enumeration and carrier structs.
  Assumes a 125 MHz core clock; link timings are given in nanoseconds.
*/
package wkm_pkg;

  // Register offsets, reset values and bit positions
  localparam logic [7:0] WKM_KEY_CODE_OFS   = 8'h5F;
  localparam logic [7:0] WKM_CLK_CFG_OFS    = 8'hF0;
  localparam logic [7:0] WKM_KEY_CODE_RST   = 8'h00;
  localparam logic [7:0] WKM_CLK_CFG_RST    = 8'h00;
  localparam int         WKM_DISABLE_BIT    = 1;
  localparam int         WKM_MATCH_BIT      = 5;

  // Frame layout
  localparam int         WKM_FRAME_BITS     = 11;
  localparam logic [3:0] WKM_EDGE_START     = 4'h1;
  localparam logic [3:0] WKM_EDGE_PARITY    = 4'hA;
  localparam logic [3:0] WKM_EDGE_STOP      = 4'hB;

  // Timing
  localparam int WKM_CLK_PERIOD_PS = 8000;
  localparam int WKM_IDLE_MIN_NS   = 115000;
  localparam int WKM_IDLE_MAX_NS   = 145000;
  localparam int WKM_SET_MAX_NS    = 100000;
  localparam int WKM_IDLE_MIN_CYC  =
    (WKM_IDLE_MIN_NS * 1000 + WKM_CLK_PERIOD_PS - 1) / WKM_CLK_PERIOD_PS;
  localparam int WKM_IDLE_MAX_CYC  = (WKM_IDLE_MAX_NS * 1000) / WKM_CLK_PERIOD_PS;
  localparam int WKM_GLITCH_CYC    = 4;

  // Matcher states
  typedef enum logic [1:0] {
    WKM_IDLE,
    WKM_ARMED,
    WKM_RECV
  } wkm_state_type;

  // Filtered link lines
  typedef struct packed {
    logic kclk;
    logic kdat;
  } wkm_link_type;

  // Register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } wkm_wreq_type;

endpackage

//--- rtl/wkm_line_filter.sv
/*
  Synchroniser and glitch filter for the keyboard clock and data lines.
  Assumes asynchronous pin inputs and a synchronously released reset.
*/
`timescale 1ns/1ps
module wkm_line_filter
  import wkm_pkg::*;
#(
  parameter int FILT_CYC = WKM_GLITCH_CYC
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Raw pins
  input  wire logic         kclk_pin,
  input  wire logic         kdat_pin,
  // Clean lines
  output wkm_link_type      lines
);

  logic [1:0] meta_q, sync_q;
  logic [1:0] stable_q, stable_d;
  logic [1:0] prev_q;
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= {kclk_pin, kdat_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // A line must hold steady for FILT_CYC + 2 cycles before it is believed
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_comb begin
        cnt_d[g]    = cnt_q[g];
        stable_d[g] = stable_q[g];
        if (sync_q[g] != prev_q[g]) begin
          cnt_d[g] = 8'h00;
        end else if (cnt_q[g] < 8'(FILT_CYC)) begin
          cnt_d[g] = cnt_q[g] + 8'h01;
        end else begin
          stable_d[g] = sync_q[g];
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q[g]    <= 8'h00;
          stable_q[g] <= 1'b1;
        end else begin
          cnt_q[g]    <= cnt_d[g];
          stable_q[g] <= stable_d[g];
        end
      end
    end
  endgenerate

  assign lines.kclk = stable_q[1];
  assign lines.kdat = stable_q[0];

endmodule

//--- bench/wkm_matcher_asserts.sv
/* Port checker for the wake-on-key matcher.
   Assumes a keyboard that keeps its clock high between frames. */
`timescale 1ns/1ps
module wkm_matcher_chk
  import wkm_pkg::*;
#(
  parameter int IDLE_MIN_CYC = WKM_IDLE_MIN_CYC
) (
  // Clock, reset and keyboard pins
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       kbd_clk_in,
  input wire logic       kbd_dat_in,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Wake status and enables
  input wire logic       match_sts_clr,
  input wire logic       match_sts,
  input wire logic       match_en,
  input wire logic       global_wake_enable,
  input wire logic       wake_out
);
  int unsigned hi_q;
  int unsigned falls_q;
  logic [10:0] sh_q;
  logic [7:0]  key_q;
  logic [7:0]  cfg_q;
  logic        kclk_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Raw pin history and register shadows; raw timing is close enough to filtered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hi_q    <= 0;
      falls_q <= 0;
      sh_q    <= '0;
      key_q   <= WKM_KEY_CODE_RST;
      cfg_q   <= WKM_CLK_CFG_RST;
      kclk_q  <= 1'b1;
    end else begin
      kclk_q <= kbd_clk_in;
      hi_q   <= kbd_clk_in ? hi_q + 1 : 0;
      if (kclk_q && !kbd_clk_in) begin
        falls_q <= (hi_q >= IDLE_MIN_CYC) ? 1 : falls_q + 1;
        sh_q    <= {kbd_dat_in, sh_q[10:1]};
      end
      if (reg_wr && reg_addr == WKM_KEY_CODE_OFS) key_q <= reg_wdata;
      if (reg_wr && reg_addr == WKM_CLK_CFG_OFS) cfg_q <= reg_wdata;
    end
  end

  sequence s_rd_key;
    reg_rd && !reg_wr && reg_addr == WKM_KEY_CODE_OFS;
  endsequence
  sequence s_set;
    $rose(match_sts);
  endsequence

  property p_rd_key;
    s_rd_key |=> reg_rdata == $past(key_q);
  endproperty
  a_rd_key: assert property (p_rd_key) else $error("key code readback wrong");
  property p_wake_sts;
    wake_out |-> $past(match_sts) && $past(match_en, 3);
  endproperty
  a_wake_sts: assert property (p_wake_sts) else $error("wake without status");
  property p_wake_glb;
    wake_out |-> $past(global_wake_enable, 3);
  endproperty
  a_wake_glb: assert property (p_wake_glb) else $error("wake without global");
  property p_sts_clr;
    match_sts_clr && hi_q > 30 |=> !match_sts;
  endproperty
  a_sts_clr: assert property (p_sts_clr) else $error("status not cleared");
  property p_quick;
    s_set |-> hi_q < 16;
  endproperty
  a_quick: assert property (p_quick) else $error("status set late");
  property p_frame;
    s_set |-> sh_q[8:1] == key_q && ^sh_q[9:1] && sh_q[10] && !sh_q[0];
  endproperty
  a_frame: assert property (p_frame) else $error("status on bad frame");
  property p_count;
    s_set |-> falls_q == WKM_FRAME_BITS;
  endproperty
  a_count: assert property (p_count) else $error("status on wrong fall");
  property p_dis;
    cfg_q[WKM_DISABLE_BIT] |-> !$rose(match_sts);
  endproperty
  a_dis: assert property (p_dis) else $error("status while disabled");
endmodule

//--- bench/wkm_kbd_model.sv
/* Keyboard model: drives clock and data for one frame at a time.
   Assumes pulled-up lines that rest high outside frames. */
`timescale 1ns/1ps
module wkm_kbd_model (
  // Keyboard lines
  output logic kclk,
  output logic kdat
);
  initial begin
    kclk = 1'b1;
    kdat = 1'b1;
  end

  // Idle gap, then 11 bits; stall holds clock high long before that bit
  task automatic send(input logic [7:0] code, input logic bad_par, input logic stop,
                      input int stall);
    logic [10:0] fr;
    fr = {stop, ~^code ^ bad_par, code, 1'b0};
    #400;
    for (int i = 0; i < 11; i++) begin
      if (i == stall) #600;
      kdat = fr[i];
      #31.25 kclk = 1'b0;
      #62.5 kclk = 1'b1;
      #31.25;
    end
    kdat = 1'b1; // Released, so the pull-up wins
  endtask
endmodule

//--- bench/testbench.sv
/* Self-checking bench for the wake-on-key matcher.
   Assumes the keyboard model and the port checker beside it. */
`timescale 1ns/1ps
module testbench
  import wkm_pkg::*;
;
  logic       core_clk, resetn, reg_wr, reg_rd, match_sts_clr, match_en, global_wake_enable;
  logic [7:0] reg_addr, reg_wdata;
  wire logic  kbd_clk, kbd_dat, match_sts, wake_out;
  wire logic [7:0] reg_rdata;
  int         err_count, num_checks;

  // Short idle counts keep the run brief
  wkm_matcher #(.IDLE_MIN_CYC(20), .IDLE_MAX_CYC(40), .FILT_CYC(4)) i_wkm_matcher (
    .core_clk(core_clk), .resetn(resetn), .kbd_clk_in(kbd_clk), .kbd_dat_in(kbd_dat),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .match_sts_clr(match_sts_clr), .match_sts(match_sts),
    .match_en(match_en), .global_wake_enable(global_wake_enable), .wake_out(wake_out));
  wkm_kbd_model i_wkm_kbd_model (.kclk(kbd_clk), .kdat(kbd_dat));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, exp);
  endtask
  task automatic en(input logic e, input logic g);
    @(posedge core_clk);
    match_en           <= e;
    global_wake_enable <= g;
  endtask
  // Negative frames watch the full window, positive ones stop at the set
  task automatic frame(input logic [7:0] c, input logic bp, input logic sb, input int st,
                       input logic exp);
    i_wkm_kbd_model.send(c, bp, sb, st);
    for (int n = 0; n < 200; n++) begin
      settle(1); // Look after the edge, once the flops have settled
      if (exp && match_sts === 1'b1) break;
    end
    chk1(match_sts, exp);
  endtask
  task automatic close_out;
    $display("TB: checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000; // Well past a clean run, inside the cycle budget
    err_count++;
    close_out;
  end

  // Mirrored, wrong, bad parity, bad stop, stalled
  logic [7:0] r_code [5] = '{8'h78, 8'h1F, 8'h1E, 8'h1E, 8'h1E};
  logic       r_par  [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic       r_stop [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  int         r_stall[5] = '{-1, -1, -1, -1, 5};

  initial begin
    {resetn, reg_wr, reg_rd, match_sts_clr, match_en, global_wake_enable} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(WKM_KEY_CODE_OFS, WKM_KEY_CODE_RST);
    rd(WKM_CLK_CFG_OFS, WKM_CLK_CFG_RST);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(WKM_KEY_CODE_OFS, 8'h1E);
    rd(WKM_KEY_CODE_OFS, 8'h1E);
    $display("TB: register test done");
    en(1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      frame(r_code[i], r_par[i], r_stop[i], r_stall[i], 1'b0);
    end
    frame(8'h1E, 1'b0, 1'b1, -1, 1'b1);
    settle(6);
    chk1(wake_out, 1'b0);
    en(1'b1, 1'b1);
    settle(6);
    chk1(wake_out, 1'b1);
    en(1'b1, 1'b0);
    settle(6);
    chk1(wake_out, 1'b0);
    chk1(match_sts, 1'b1);
    settle(20);
    @(posedge core_clk);
    match_sts_clr <= 1'b1;
    @(posedge core_clk);
    match_sts_clr <= 1'b0;
    settle(2);
    chk1(match_sts, 1'b0);
    $display("TB: frame test done");
    en(1'b1, 1'b1);
    wr(WKM_CLK_CFG_OFS, 8'h02);
    rd(WKM_CLK_CFG_OFS, 8'h02);
    frame(8'h1E, 1'b0, 1'b1, -1, 1'b0);
    chk1(wake_out, 1'b0);
    wr(WKM_CLK_CFG_OFS, 8'h00);
    frame(8'h1E, 1'b0, 1'b1, -1, 1'b1);
    settle(6);
    chk1(wake_out, 1'b1);
    $display("TB: disable test done");
    close_out;
  end
endmodule

bind wkm_matcher wkm_matcher_chk #(.IDLE_MIN_CYC(IDLE_MIN_CYC)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .kbd_clk_in(kbd_clk_in), .kbd_dat_in(kbd_dat_in),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .match_sts_clr(match_sts_clr), .match_sts(match_sts),
  .match_en(match_en), .global_wake_enable(global_wake_enable), .wake_out(wake_out));
